/* btod_regs.svh */
// Offsets, field positions, reset values and timing counts of the port.
`ifndef BTOD_REGS_SVH
`define BTOD_REGS_SVH
`define BTOD_CMD_OFS 4'ha
`define BTOD_DATA_OFS 4'hb
`define BTOD_CMD_RST 8'h00
`define BTOD_CMD_FREEZE 6
`define BTOD_CMD_WRITE 5
`define BTOD_CMD_READ 4
`define BTOD_SEC_NS 1000000000
`define BTOD_CLK_NS 8
`define BTOD_SEC_CYC (`BTOD_SEC_NS / `BTOD_CLK_NS)
`endif

/* btod_pkg.sv */
// Types shared by the time-of-day port.
`default_nettype none
package btod_pkg;
  typedef enum logic [3:0] {
    BTOD_SEC1 = 4'h0, BTOD_SEC10 = 4'h1, BTOD_MIN1 = 4'h2,
    BTOD_MIN10 = 4'h3, BTOD_HR1 = 4'h4, BTOD_HR10 = 4'h5,
    BTOD_WDAY = 4'h6, BTOD_DAY1 = 4'h7, BTOD_DAY10 = 4'h8,
    BTOD_MON1 = 4'h9, BTOD_MON10 = 4'ha, BTOD_YR1 = 4'hb,
    BTOD_YR10 = 4'hc
  } btod_digit_e;
  typedef logic [3:0] btod_nib_t;
endpackage
`default_nettype wire

/* btod_port.sv */
// Time-of-day and calendar clock behind a command port and a data port.
// Functional notes
// RL1 - Data port carries one BCD digit in low nibble; high nibble reads zero.
// RL2 - Hours tens bit 3 picks 24-hour mode; bit 2 marks PM in 12-hour.
// RL3 - Hours tens bit 1 is zero in 12-hour, value bit in 24-hour.
// RL4 - Hours tens never exceeds 2, days tens never exceeds 3.
// RL5 - Leap flag gives February 29 days; device clears it after the 29th.
// RL6 - Writing either seconds digit loads zero regardless of data.
// RL7 - Host starts setting time by writing 40h to the command port.
// RL8 - Host per digit: select, write data, raise write, drop write.
// RL9 - Host writes zero to the command port after the last digit.
// RL10 - Read: select digit with read high, then read the data port.
// RL11 - Host writes zero to the command port after reading.
// RL12 - Freeze stops counting; keep it under one second.
// RL13 - Slow samplers should freeze during reads to avoid torn digits.
// RL14 - Host programs and masks mode, AM/PM and leap flags itself.
// RL15 - Command bit 6 freezes, bit 5 writes digit, bit 4 reads digit.
// RL16 - Command bits 3..0 select digits 0 to 12 in time order.
// RL17 - Without read or write, data port reads zero and nothing changes.
// RL18 - Reset clears the command port, counters keep running; the prescaler is held at zero while reset is high.
`timescale 1ns/1ns
`default_nettype none
`include "btod_regs.svh"
module btod_port
  import btod_pkg::*;
#(
  parameter int unsigned SEC_CYC = `BTOD_SEC_CYC
) (
  input wire logic mclk_i, // System clock, 125 MHz.
  input wire logic sys_rst_i, // Synchronous reset, active high.
  input wire logic [3:0] port_addr_i, // Port offset within the block.
  input wire logic port_wr_i, // One-cycle port write strobe.
  input wire logic port_rd_i, // One-cycle port read strobe.
  input wire logic [7:0] port_wdata_i, // Write data.
  output logic [7:0] port_rdata_o, // Read data, one cycle after strobe.
  output logic port_rvalid_o // Read data valid pulse.
);

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] wdat;
    logic [31:0] presc;
    btod_nib_t [12:0] dig;
    logic [7:0] rdata;
    logic rvalid;
  } btod_state_s;

  btod_state_s cur_ff;
  btod_state_s nxt_st;

  // Days in a month from month digits and leap flag.
  function automatic logic [5:0] btod_mdays(input btod_nib_t m1,
                                             input btod_nib_t m10,
                                             input logic leap);
    logic [4:0] m;
    m = 5'(m10[0] ? 5'd10 + 5'(m1) : 5'(m1));
    case (m)
      5'd2: btod_mdays = leap ? 6'h29 : 6'h28; // RL5
      5'd4, 5'd6, 5'd9, 5'd11: btod_mdays = 6'h30;
      default: btod_mdays = 6'h31;
    endcase
  endfunction

  // Next state: port access, digit writes and timekeeping.
  always_comb begin
    logic tick;
    logic carry;
    logic [5:0] hr;
    logic [5:0] dy;
    logic [3:0] sel;
    tick = 1'b0;
    carry = 1'b0;
    hr = 6'h00;
    dy = 6'h00;
    sel = 4'h0;
    nxt_st = cur_ff;
    nxt_st.rvalid = 1'b0;
    // Command and data port writes.
    if (port_wr_i && port_addr_i == `BTOD_CMD_OFS) begin
      nxt_st.cmd = {1'b0, port_wdata_i[6:0]}; // RL15
    end
    if (port_wr_i && port_addr_i == `BTOD_DATA_OFS) begin
      nxt_st.wdat = {4'h0, port_wdata_i[3:0]}; // RL1
    end
    // Digit select comes from the stored command byte.
    sel = cur_ff.cmd[3:0];
    // Reads present the selected digit only while read is high.
    if (port_rd_i) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = 8'h00; // RL17
      if (port_addr_i == `BTOD_DATA_OFS && cur_ff.cmd[`BTOD_CMD_READ] &&
          sel <= 4'hc) begin
        nxt_st.rdata = {4'h0, cur_ff.dig[sel]}; // RL1 RL10 RL16
      end
    end
    // Holding freeze past one second loses time; nothing flags it.
    // Seconds prescaler, halted while frozen.
    if (!cur_ff.cmd[`BTOD_CMD_FREEZE]) begin // RL12
      if (cur_ff.presc >= SEC_CYC - 1) begin
        nxt_st.presc = 32'h0;
        tick = 1'b1;
      end else begin
        nxt_st.presc = cur_ff.presc + 32'h1;
      end
    end
    if (tick) begin
      carry = 1'b1;
      // Seconds and minutes cascade.
      for (int i = 0; i < 4; i = i + 2) begin
        if (carry) begin
          carry = 1'b0;
          if (cur_ff.dig[i] == 4'h9) begin
            nxt_st.dig[i] = 4'h0;
            if (cur_ff.dig[i+1] == 4'h5) begin
              nxt_st.dig[i+1] = 4'h0;
              carry = 1'b1;
            end else begin
              nxt_st.dig[i+1] = cur_ff.dig[i+1] + 4'h1;
            end
          end else begin
            nxt_st.dig[i] = cur_ff.dig[i] + 4'h1;
          end
        end
      end
      // Hours in 12 or 24 hour form.
      if (carry) begin
        carry = 1'b0;
        hr = {cur_ff.dig[BTOD_HR10][1:0], cur_ff.dig[BTOD_HR1]};
        // Bit 3 of the hours tens digit picks 24-hour counting.
        if (cur_ff.dig[BTOD_HR10][3]) begin // RL2
          if (hr == 6'h23) begin
            hr = 6'h00;
            carry = 1'b1;
          end else if (hr[3:0] == 4'h9) begin
            hr = {hr[5:4] + 2'h1, 4'h0};
          end else begin
            hr = {hr[5:4], hr[3:0] + 4'h1};
          end
          nxt_st.dig[BTOD_HR10] = {2'b10, hr[5:4]}; // RL3 RL4
        end else begin
          if (hr == 6'h12) begin
            hr = 6'h01;
          end else if (hr == 6'h09) begin
            hr = 6'h10;
          end else begin
            hr = {hr[5:4], hr[3:0] + 4'h1};
          end
          // The PM flag flips on 11 to 12; the day moves on PM to AM only.
          nxt_st.dig[BTOD_HR10][2] = cur_ff.dig[BTOD_HR10][2];
          if (hr == 6'h12) begin
            nxt_st.dig[BTOD_HR10][2] = ~cur_ff.dig[BTOD_HR10][2]; // RL2
            carry = cur_ff.dig[BTOD_HR10][2];
          end
          nxt_st.dig[BTOD_HR10][3] = 1'b0;
          nxt_st.dig[BTOD_HR10][1:0] = {1'b0, hr[4]}; // RL3
        end
        nxt_st.dig[BTOD_HR1] = hr[3:0];
      end
      // Day of week, day of month, month, year.
      if (carry) begin
        nxt_st.dig[BTOD_WDAY] = cur_ff.dig[BTOD_WDAY] == 4'h6 ? 4'h0 :
                                cur_ff.dig[BTOD_WDAY] + 4'h1;
        dy = {cur_ff.dig[BTOD_DAY10][1:0], cur_ff.dig[BTOD_DAY1]};
        if (dy == btod_mdays(cur_ff.dig[BTOD_MON1], cur_ff.dig[BTOD_MON10],
                             cur_ff.dig[BTOD_DAY10][2])) begin
          nxt_st.dig[BTOD_DAY1] = 4'h1;
          nxt_st.dig[BTOD_DAY10] = {1'b0, cur_ff.dig[BTOD_DAY10][2], 2'b00};
          // Leaving February 29 drops the leap flag; the host sets it again.
          if (dy == 6'h29) begin
            nxt_st.dig[BTOD_DAY10][2] = 1'b0; // RL5
          end
          if (cur_ff.dig[BTOD_MON10][0] && cur_ff.dig[BTOD_MON1] == 4'h2)
          begin
            nxt_st.dig[BTOD_MON1] = 4'h1;
            nxt_st.dig[BTOD_MON10] = 4'h0;
            if (cur_ff.dig[BTOD_YR1] == 4'h9) begin
              nxt_st.dig[BTOD_YR1] = 4'h0;
              nxt_st.dig[BTOD_YR10] = cur_ff.dig[BTOD_YR10] == 4'h9 ? 4'h0 :
                                      cur_ff.dig[BTOD_YR10] + 4'h1;
            end else begin
              nxt_st.dig[BTOD_YR1] = cur_ff.dig[BTOD_YR1] + 4'h1;
            end
          end else if (cur_ff.dig[BTOD_MON1] == 4'h9) begin
            nxt_st.dig[BTOD_MON1] = 4'h0;
            nxt_st.dig[BTOD_MON10] = 4'h1;
          end else begin
            nxt_st.dig[BTOD_MON1] = cur_ff.dig[BTOD_MON1] + 4'h1;
          end
        end else if (dy[3:0] == 4'h9) begin
          nxt_st.dig[BTOD_DAY1] = 4'h0;
          nxt_st.dig[BTOD_DAY10][1:0] = dy[5:4] + 2'h1; // RL4
        end else begin
          nxt_st.dig[BTOD_DAY1] = dy[3:0] + 4'h1;
        end
      end
    end
    // Host digit write wins over the count on the same cycle.
    if (cur_ff.cmd[`BTOD_CMD_WRITE] && sel <= 4'hc) begin // RL15
      case (sel)
        4'h0, 4'h1: nxt_st.dig[sel] = 4'h0; // RL6
        default: nxt_st.dig[sel] = cur_ff.wdat[3:0]; // RL16
      endcase
    end
    // Reset clears the command, read data, valid and prescaler only, so the digits and the write data keep their values.
    if (sys_rst_i) begin
      nxt_st.cmd = `BTOD_CMD_RST; // RL18
      nxt_st.rdata = 8'h00;
      nxt_st.rvalid = 1'b0;
      nxt_st.presc = 32'h0;
    end
  end

  // State register; time digits survive reset like a backed-up clock.
  always_ff @(posedge mclk_i) begin
    cur_ff <= nxt_st;
  end

  // Outputs come straight from the state register.
  assign port_rdata_o = cur_ff.rdata;
  assign port_rvalid_o = cur_ff.rvalid;

endmodule
`default_nettype wire

/* btod_port_monitor.sv */
// Checker for the time-of-day port pins.
`timescale 1ns/1ns
`default_nettype none
`include "btod_regs.svh"
module btod_port_monitor (
  input wire logic mclk_i, // Clock.
  input wire logic sys_rst_i, // Reset.
  input wire logic [3:0] port_addr_i, // Offset.
  input wire logic port_wr_i, // Write strobe.
  input wire logic port_rd_i, // Read strobe.
  input wire logic [7:0] port_wdata_i, // Write data.
  input wire logic [7:0] port_rdata_o, // Read data.
  input wire logic port_rvalid_o // Read valid.
);
  logic [7:0] cmd_ff;
  logic drd;
  // Shadow of the command byte, so data reads can be judged.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cmd_ff <= `BTOD_CMD_RST;
    end else if (port_wr_i && port_addr_i == `BTOD_CMD_OFS) begin
      cmd_ff <= port_wdata_i;
    end
  end
  // Data port reads with the read bit set.
  assign drd = port_rd_i && port_addr_i == `BTOD_DATA_OFS &&
               cmd_ff[`BTOD_CMD_READ];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  AST_RVALID: assert property (port_rd_i |=> port_rvalid_o)
    else $error("no valid after read");
  AST_NO_RVALID: assert property (!port_rd_i |=> !port_rvalid_o)
    else $error("valid without read");
  AST_HI_NIB: assert property (port_rvalid_o |-> !(|port_rdata_o[7:4]))
    else $error("high nibble set");
  AST_OTHER: assert property (
    port_rd_i && port_addr_i != `BTOD_DATA_OFS |=> port_rdata_o == 8'h00)
    else $error("non data port read");
  AST_NOREAD: assert property (
    port_rd_i && port_addr_i == `BTOD_DATA_OFS && !cmd_ff[`BTOD_CMD_READ]
    |=> port_rdata_o == 8'h00) else $error("read bit off");
  AST_SEL: assert property (
    drd && cmd_ff[3:0] > 4'hc |=> port_rdata_o == 8'h00)
    else $error("bad select");
  AST_HR12: assert property (
    drd && cmd_ff[3:0] == 4'h5 |=> port_rdata_o[3] || !port_rdata_o[1])
    else $error("hour bit");
  AST_HRMAX: assert property (
    drd && cmd_ff[3:0] == 4'h5 |=> port_rdata_o[1:0] != 2'h3)
    else $error("hour tens high");
  AST_RESET: assert property (
    $fell(sys_rst_i) |-> !port_rvalid_o && port_rdata_o == 8'h00)
    else $error("reset state");
endmodule
bind btod_port btod_port_monitor MON (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .port_addr_i(port_addr_i), .port_wr_i(port_wr_i), .port_rd_i(port_rd_i),
  .port_wdata_i(port_wdata_i), .port_rdata_o(port_rdata_o),
  .port_rvalid_o(port_rvalid_o));
`default_nettype wire

/* btod_host.sv */
// Host processor model issuing port writes and reads.
`timescale 1ns/1ns
`default_nettype none
module btod_host (
  input wire logic mclk_i, // Clock.
  output logic [3:0] addr_o, // Offset.
  output logic wr_o, // Write strobe.
  output logic rd_o, // Read strobe.
  output logic [7:0] wdata_o // Write data.
);
  // Idle bus at time zero.
  initial begin
    addr_o = 4'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // One access; the released data bus shows the inverted value.
  task automatic xfer(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  // Writes one digit with the counters held.
  task automatic put(input logic [3:0] sel, input logic [3:0] v);
    xfer(4'ha, {4'h4, sel}, 1'b1);
    xfer(4'hb, {4'h0, v}, 1'b1);
    xfer(4'ha, {4'h6, sel}, 1'b1);
    xfer(4'ha, {4'h4, sel}, 1'b1);
  endtask
endmodule
`default_nettype wire

/* btod_port_test.sv */
// Self-checking bench for the time-of-day port.
`timescale 1ns/1ns
`default_nettype none
module btod_port_test;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr;
  logic wr, rd, rvalid;
  logic [7:0] wdata, rdata;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  logic [3:0] v[13] = '{0, 0, 9, 5, 3, 4'ha, 0, 8, 6, 2, 0, 0, 0};
  int miscompares = 0;
  int comparisons = 0;
  `define CHK(e, g) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] rdata exp %h got %h", e, g); end end
  always #4 mclk_i = ~mclk_i;
  btod_host HOST (.mclk_i(mclk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata));
  btod_port #(.SEC_CYC(200)) DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .port_addr_i(addr), .port_wr_i(wr), .port_rd_i(rd), .port_wdata_i(wdata),
    .port_rdata_o(rdata), .port_rvalid_o(rvalid));
  // Pairs each answer with the oldest expectation.
  always @(posedge mclk_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("[FAIL] rdata exp none got %h", rdata);
      end else begin
        exp_v = exp_q.pop_front();
        `CHK(exp_v, rdata)
      end
    end
  end
  task automatic chk(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    HOST.xfer(a, 8'h00, 1'b0);
  endtask
  // Reads one digit with the hold bit set.
  task automatic dig(input logic [3:0] s, input logic [7:0] e);
    HOST.xfer(4'ha, {4'h5, s}, 1'b1);
    chk(4'hb, e);
  endtask
  task automatic end_sim;
    if (exp_q.size() != 0) miscompares++;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (40000) @(posedge mclk_i);
    miscompares++;
    end_sim();
  end
  // Main sequence: set a leap-year date just before midnight, let it roll.
  initial begin
    void'($urandom(96522));
    v[0] = 4'(1 + $urandom % 9);
    v[1] = 4'(1 + $urandom % 5);
    v[6] = 4'($urandom % 7);
    v[11] = 4'($urandom % 10);
    v[12] = v[11];
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    chk(4'ha, 8'h00);
    chk(4'h3, 8'h00);
    chk(4'hb, 8'h00);
    HOST.xfer(4'ha, 8'h40, 1'b1);
    for (int i = 0; i < 13; i++) HOST.put(4'(i), v[i]);
    dig(4'h0, 8'h00);
    dig(4'h1, 8'h00);
    dig(4'h5, 8'h0a);
    dig(4'hd, 8'h00);
    dig(4'hc, {4'h0, v[12]});
    HOST.xfer(4'ha, 8'h00, 1'b1);
    repeat (12400) @(posedge mclk_i);
    dig(4'h3, 8'h00);
    dig(4'h4, 8'h00);
    dig(4'h5, 8'h08);
    dig(4'h6, (v[6] == 4'h6) ? 8'h00 : {4'h0, v[6] + 4'h1});
    dig(4'h7, 8'h09);
    dig(4'h8, 8'h06);
    HOST.xfer(4'ha, 8'h00, 1'b1);
    // Second pass: 11:59 PM in 12-hour form on the leap day.
    HOST.xfer(4'ha, 8'h40, 1'b1);
    HOST.put(4'h0, v[1]);
    HOST.put(4'h1, v[0]);
    HOST.put(4'h2, 4'h9);
    HOST.put(4'h3, 4'h5);
    HOST.put(4'h4, 4'h1);
    HOST.put(4'h5, 4'h5);
    dig(4'h1, 8'h00);
    dig(4'h5, 8'h05);
    HOST.xfer(4'ha, 8'h00, 1'b1);
    repeat (12400) @(posedge mclk_i);
    dig(4'h4, 8'h02);
    dig(4'h5, 8'h01);
    dig(4'h7, 8'h01);
    dig(4'h8, 8'h00);
    dig(4'h9, 8'h03);
    HOST.xfer(4'ha, 8'h15, 1'b1);
    // A reset in mid-run must drop the read bit from the command.
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    chk(4'hb, 8'h00);
    repeat (4) @(posedge mclk_i);
    end_sim();
  end
endmodule
`default_nettype wire
